// file: rtl/phy_led_mdix_bist_control.sv
// led override and transceiver control registers with avalon-mm slave
`timescale 1ns/10ps
module phy_led_mdix_bist_control import phy_ledctl_pkg::*; #(
  parameter int STRETCH_CYCLES = 5000000
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  // strap pins
  input wire logic strap_auto_crossover,
  input wire logic strap_indicator_mode,
  input wire logic [PADDR_W-1:0] strap_port_address,
  // link and negotiation state from the transceiver core
  input wire link_evt_s link_evt,
  input wire pause_ab_s local_ability,
  input wire pause_ab_s partner_ability,
  input wire logic hcd_full_duplex,
  input wire logic selftest_nibble_err,
  // controls towards the transceiver core and pins
  output logic link_indicator_pin,
  output logic auto_crossover_enable,
  output logic crossover_force,
  output logic selftest_run,
  output logic selftest_sequence_select,
  output logic selftest_error_inject,
  output logic [PADDR_W-1:0] port_mgmt_address
);

  localparam int STR_W = $clog2(STRETCH_CYCLES + 1);
  localparam int LAT1 = 1;
  localparam int LAT2 = 2;

  bus_state_e state_r;
  logic [15:0] led_r;
  logic [15:0] ctrl_r;
  logic pause_rx_r;
  logic pause_tx_r;
  logic pass_r;
  logic run_prev_r;
  logic [FAULT_W-1:0] fault_r;
  logic [IRQ_W-1:0] irq_st_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [STR_W-1:0] stretch_r;
  logic [1:0] settle_r;
  logic strap_done_r;
  logic strap_arm_r;

  // strap pins come from outside the clock domain
  logic [STRAP_W-1:0] strap_sync;
  pin_sync3 #(.WIDTH(STRAP_W)) u_strap_sync (
    .clk(clk),
    .reset_n(reset_n),
    .pin_in({strap_auto_crossover, strap_indicator_mode,
             strap_port_address}),
    .pin_out(strap_sync)
  );

  // bus decode
  wire [5:0] idx = address[7:2];
  wire hit_led = (idx == IDX_LED);
  wire hit_ctrl = (idx == IDX_CTRL);
  wire hit_fault = (idx == IDX_FAULT);
  wire hit_st = (idx == IDX_IRQ_ST);
  wire hit_mask = (idx == IDX_IRQ_MASK);
  wire acc_done = (state_r == BUS_DONE);
  wire wr_done = acc_done && write;
  wire [15:0] be_mask = {{8{byteenable[1]}}, {8{byteenable[0]}}};
  wire [15:0] wdata = writedata[15:0] & be_mask;

  // read views: reserved bits masked to zero, pin state never shown
  wire [15:0] led_rd = led_r & LED_RW_MASK;
  wire [15:0] ctrl_status = (16'(pause_rx_r) << PRX_BIT) |
                            (16'(pause_tx_r) << PTX_BIT) |
                            (16'(pass_r) << PASS_BIT);
  wire [15:0] ctrl_rd = (ctrl_r & CTRL_RW_MASK) | ctrl_status;
  wire [31:0] rd_mux = hit_led ? {16'h0000, led_rd} :
                       hit_ctrl ? {16'h0000, ctrl_rd} :
                       hit_fault ? {24'h000000, fault_r} :
                       hit_st ? {30'h00000000, irq_st_r} :
                       hit_mask ? {30'h00000000, irq_mask_r} :
                       32'h00000000;

  // led override register; byte-lane merge, reserved lanes dropped
  wire led_we = wr_done && hit_led;
  wire [15:0] led_nxt = led_we ?
    ((led_r & ~(be_mask & LED_RW_MASK)) | (wdata & LED_RW_MASK)) :
    led_r;

  // control register write merge
  wire ctrl_we = wr_done && hit_ctrl;
  wire [15:0] ctrl_wmask = be_mask & CTRL_RW_MASK;
  wire [15:0] ctrl_wr = (ctrl_r & ~ctrl_wmask) | (wdata & CTRL_RW_MASK);
  // inject bit self-clears one cycle after it is set
  wire [15:0] ctrl_sc = ctrl_r & ~(16'h0001 << INJ_BIT);
  // armed one cycle after settle so the filtered strap copy is valid
  wire strap_load = !strap_done_r && strap_arm_r;
  wire [15:0] strap_val = (16'(strap_sync[6]) << MDIX_BIT) |
                          (16'(strap_sync[5]) << MODE_BIT) |
                          16'(strap_sync[4:0]);
  wire [15:0] strap_keep = ~((16'h0001 << MDIX_BIT) |
                             (16'h0001 << MODE_BIT) | 16'h001f);
  // a write in the strap load cycle still wins over the strap
  wire [15:0] ctrl_nxt = ctrl_we ? ctrl_wr :
                         strap_load ? ((ctrl_sc & strap_keep) | strap_val) :
                         ctrl_sc;

  // pause resolution, symmetric and asymmetric cases
  wire lp = local_ability.pause;
  wire la = local_ability.asm_dir;
  wire pp = partner_ability.pause;
  wire pa = partner_ability.asm_dir;
  wire rx_res = hcd_full_duplex &&
                ((lp && pp) || (lp && la && !pp && pa));
  wire tx_res = hcd_full_duplex &&
                ((lp && pp) || (!lp && la && pp && pa));

  // self-test run, pass latch and fault counter
  wire run = ctrl_r[RUN_BIT];
  wire run_rise = run && !run_prev_r;
  wire test_err = selftest_nibble_err || ctrl_r[INJ_BIT];
  wire pass_nxt = !run ? 1'b0 :
                  run_rise ? 1'b1 :
                  test_err ? 1'b0 : pass_r;
  wire fault_inc = run && !run_rise && selftest_nibble_err &&
                   (fault_r != FAULT_MAX);
  wire [FAULT_W-1:0] fault_nxt = run_rise ? '0 :
    fault_inc ? FAULT_W'(fault_r + 1'b1) : fault_r;

  // interrupts: set wins over a write-one clear in the same cycle
  wire [IRQ_W-1:0] irq_ev;
  assign irq_ev[IRQ_FAIL_BIT] = pass_r && !pass_nxt && run;
  assign irq_ev[IRQ_PAUSE_BIT] = (rx_res != pause_rx_r) ||
                                 (tx_res != pause_tx_r);
  wire [IRQ_W-1:0] st_clr = (wr_done && hit_st) ?
                            writedata[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] st_nxt = (irq_st_r & ~st_clr) | irq_ev;
  wire [IRQ_W-1:0] mask_nxt = (wr_done && hit_mask) ?
                              writedata[IRQ_W-1:0] : irq_mask_r;

  // indicator: stretch holds a blink long enough for the eye to see
  wire act = link_evt.activity;
  wire [STR_W-1:0] stretch_nxt = act ? STR_W'(STRETCH_CYCLES) :
    (stretch_r != '0) ? STR_W'(stretch_r - 1'b1) : stretch_r;
  wire act_seen = ctrl_r[BYP_BIT] ? act : (stretch_r != '0);
  wire led_raw = ctrl_r[MODE_BIT] ? link_evt.link_up :
                 (link_evt.link_up && !act_seen);
  wire pin_nxt = led_r[LED_EN_BIT] ? led_r[LED_VAL_BIT] : led_raw;

  // bus handshake: one wait cycle, answer at the second edge
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r <= BUS_IDLE;
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
    end else begin
      unique case (state_r)
        BUS_IDLE: begin
          if (read || write) begin
            state_r <= BUS_DONE;
            waitrequest <= 1'b0;
            readdata <= rd_mux;
          end
        end
        BUS_DONE: begin
          state_r <= BUS_IDLE;
          waitrequest <= 1'b1;
        end
        default: begin
          state_r <= BUS_IDLE;
          waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // register state
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      led_r <= LED_RESET;
      ctrl_r <= CTRL_RESET;
      pause_rx_r <= 1'b0;
      pause_tx_r <= 1'b0;
      pass_r <= 1'b0;
      run_prev_r <= 1'b0;
      fault_r <= '0;
      irq_st_r <= IRQ_RESET;
      irq_mask_r <= IRQ_RESET;
    end else begin
      led_r <= led_nxt;
      ctrl_r <= ctrl_nxt;
      pause_rx_r <= rx_res;
      pause_tx_r <= tx_res;
      pass_r <= pass_nxt;
      run_prev_r <= run;
      fault_r <= fault_nxt;
      irq_st_r <= st_nxt;
      irq_mask_r <= mask_nxt;
    end
  end

  // strap capture after the synchroniser has settled
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      settle_r <= 2'h0;
      strap_done_r <= 1'b0;
      strap_arm_r <= 1'b0;
    end else begin
      strap_arm_r <= (settle_r == STRAP_SETTLE);
      if (settle_r != STRAP_SETTLE) begin
        settle_r <= settle_r + 2'h1;
      end
      if (strap_load) begin
        strap_done_r <= 1'b1;
      end
    end
  end

  // outputs, all registered
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stretch_r <= '0;
      link_indicator_pin <= 1'b0;
      auto_crossover_enable <= 1'b0;
      crossover_force <= 1'b0;
      selftest_run <= 1'b0;
      selftest_sequence_select <= 1'b0;
      selftest_error_inject <= 1'b0;
      port_mgmt_address <= '0;
      irq <= 1'b0;
    end else begin
      stretch_r <= stretch_nxt;
      link_indicator_pin <= pin_nxt;
      auto_crossover_enable <= ctrl_r[MDIX_BIT];
      crossover_force <= ctrl_r[FMDIX_BIT];
      selftest_run <= run;
      selftest_sequence_select <= ctrl_r[SEQ_BIT];
      selftest_error_inject <= ctrl_r[INJ_BIT];
      port_mgmt_address <= ctrl_r[PADDR_W-1:PADDR_LSB];
      irq <= |(irq_st_r & irq_mask_r);
    end
  end

  // checks
  property p_led_rsv;
    @(posedge clk) disable iff (!reset_n)
      (led_rd & ~LED_RW_MASK) == 16'h0000 &&
      (ctrl_rd & 16'h0040) == 16'h0000;
  endproperty
  a_led_rsv: assert property (p_led_rsv)
    else $error("reserved bits read nonzero");

  property p_override;
    @(posedge clk) disable iff (!reset_n)
      led_r[LED_EN_BIT] |=> link_indicator_pin == $past(led_r[LED_VAL_BIT]);
  endproperty
  a_override: assert property (p_override)
    else $error("indicator not forced");

  property p_force_store;
    @(posedge clk) disable iff (!reset_n)
      led_we && byteenable[0] |=> led_r[LED_VAL_BIT] ==
        $past(writedata[LED_VAL_BIT]);
  endproperty
  a_force_store: assert property (p_force_store)
    else $error("force value not stored");

  property p_no_pin_read;
    @(posedge clk) disable iff (!reset_n)
      state_r == BUS_IDLE && read && hit_led |=>
        readdata[15:0] == $past(led_rd);
  endproperty
  a_no_pin_read: assert property (p_no_pin_read)
    else $error("override read not from storage");

  property p_cross;
    @(posedge clk) disable iff (!reset_n)
      ##LAT1 crossover_force == $past(ctrl_r[FMDIX_BIT]);
  endproperty
  a_cross: assert property (p_cross)
    else $error("pair cross output mismatch");

  property p_pause_hd;
    @(posedge clk) disable iff (!reset_n)
      !hcd_full_duplex |=> !pause_rx_r && !pause_tx_r;
  endproperty
  a_pause_hd: assert property (p_pause_hd)
    else $error("pause resolved without full duplex");

  property p_inject_once;
    @(posedge clk) disable iff (!reset_n)
      $rose(selftest_error_inject) |=> !selftest_error_inject;
  endproperty
  a_inject_once: assert property (p_inject_once)
    else $error("error inject not a single pulse");

  property p_pass_stop;
    @(posedge clk) disable iff (!reset_n)
      $fell(run) |-> ##[0:LAT1] !pass_r;
  endproperty
  a_pass_stop: assert property (p_pass_stop)
    else $error("pass flag not cleared on stop");

  property p_pass_latch;
    @(posedge clk) disable iff (!reset_n)
      !pass_r && run && !run_rise |=> !pass_r;
  endproperty
  a_pass_latch: assert property (p_pass_latch)
    else $error("pass flag did not stay low");

  property p_fault_sat;
    @(posedge clk) disable iff (!reset_n)
      fault_r == FAULT_MAX && !run_rise |=> fault_r == FAULT_MAX;
  endproperty
  a_fault_sat: assert property (p_fault_sat)
    else $error("fault counter wrapped");

  property p_addr_out;
    @(posedge clk) disable iff (!reset_n)
      ctrl_we && byteenable[0] |-> ##LAT2 port_mgmt_address ==
        $past(writedata[PADDR_W-1:0], 2);
  endproperty
  a_addr_out: assert property (p_addr_out)
    else $error("port address not updated");

  c_write: cover property (@(posedge clk) disable iff (!reset_n)
    ctrl_we);
  c_fail: cover property (@(posedge clk) disable iff (!reset_n)
    irq_ev[IRQ_FAIL_BIT]);
  c_override: cover property (@(posedge clk) disable iff (!reset_n)
    led_r[LED_EN_BIT] && led_r[LED_VAL_BIT]);
  c_irq: cover property (@(posedge clk) disable iff (!reset_n) irq);

endmodule : phy_led_mdix_bist_control

// file: rtl/phy_ledctl_pkg.sv
// constants, field layouts and carrier types for the led/transceiver block
package phy_ledctl_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_LED = 6'h18;
  localparam logic [5:0] IDX_CTRL = 6'h19;
  localparam logic [5:0] IDX_FAULT = 6'h1c;
  localparam logic [5:0] IDX_IRQ_ST = 6'h1d;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h1e;
  localparam int ADDR_W = 8;
  localparam int REG_W = 16;

  // link_led_override fields
  localparam int LED_EN_BIT = 4;
  localparam int LED_VAL_BIT = 1;
  localparam logic [15:0] LED_RW_MASK = 16'h0012;
  localparam logic [15:0] LED_RESET = 16'h0000;

  // transceiver_control fields
  localparam int MDIX_BIT = 15;
  localparam int FMDIX_BIT = 14;
  localparam int PRX_BIT = 13;
  localparam int PTX_BIT = 12;
  localparam int INJ_BIT = 11;
  localparam int SEQ_BIT = 10;
  localparam int PASS_BIT = 9;
  localparam int RUN_BIT = 8;
  localparam int BYP_BIT = 7;
  localparam int MODE_BIT = 5;
  localparam int PADDR_LSB = 0;
  localparam int PADDR_W = 5;
  localparam logic [15:0] CTRL_RW_MASK = 16'hcdbf;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // interrupt status / mask layout
  localparam int IRQ_W = 2;
  localparam int IRQ_FAIL_BIT = 0;
  localparam int IRQ_PAUSE_BIT = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // self-test fault counter
  localparam int FAULT_W = 8;
  localparam logic [7:0] FAULT_MAX = 8'hff;

  // strap capture and pin synchroniser
  localparam int SYNC_STAGES = 3;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  localparam int STRAP_W = 7;

  typedef struct packed {
    logic asm_dir;
    logic pause;
  } pause_ab_s;

  typedef struct packed {
    logic link_up;
    logic activity;
  } link_evt_s;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } bus_state_e;

endpackage : phy_ledctl_pkg

// file: rtl/pin_sync3.sv
// three-stage pin synchroniser that accepts a change once stages agree
`timescale 1ns/10ps
module pin_sync3 import phy_ledctl_pkg::*; #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // asynchronous pin level and its filtered copy
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] out_nxt;

  // stage one is read only by stage two
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      assign out_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : pin_out[i];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      pin_out <= '0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pin_out <= out_nxt;
    end
  end

endmodule : pin_sync3

// file: test/core_model.sv
// behavioural transceiver core that feeds nibble errors to the block
`timescale 1ns/10ps
module core_model import phy_ledctl_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // burst request from the bench
  input wire logic err_go,
  input wire logic [8:0] err_count,
  // self-test handshake
  input wire logic selftest_run,
  output logic selftest_nibble_err
);
  logic [8:0] left_r;
  logic gap_r;
  // one error every other cycle, and only while the test runs
  always @(posedge clk) begin
    if (!reset_n) begin
      left_r <= 9'h000;
      gap_r <= 1'b0;
      selftest_nibble_err <= 1'b0;
    end else begin
      gap_r <= ~gap_r;
      selftest_nibble_err <= 1'b0;
      if (err_go) begin
        left_r <= err_count;
      end else if (selftest_run && left_r != 9'h000 && gap_r) begin
        selftest_nibble_err <= 1'b1;
        left_r <= left_r - 9'h001;
      end
    end
  end
endmodule : core_model

// file: test/phy_led_mdix_bist_control_tb.sv
// register bench for the led override and transceiver control block
`timescale 1ns/10ps
module phy_led_mdix_bist_control_tb import phy_ledctl_pkg::*;;
  localparam logic [7:0] A_LED = {IDX_LED, 2'b00};
  localparam logic [7:0] A_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [7:0] A_FLT = {IDX_FAULT, 2'b00};
  localparam logic [7:0] A_ST = {IDX_IRQ_ST, 2'b00};
  localparam logic [7:0] A_MSK = {IDX_IRQ_MASK, 2'b00};
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [ADDR_W-1:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = '0;
  logic [3:0] byteenable = 4'h3;
  logic [31:0] readdata;
  logic waitrequest;
  logic irq;
  link_evt_s link_evt = '0;
  pause_ab_s local_ability = '0;
  pause_ab_s partner_ability = '0;
  logic hcd_full_duplex = 1'b0;
  logic selftest_nibble_err;
  logic pin, acen, xf, run, seq, inj;
  logic [PADDR_W-1:0] paddr;
  logic err_go = 1'b0;
  logic [8:0] err_count = '0;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  int inj_cnt = 0;
  logic [31:0] rd;
  logic [6:0] ptab [5];

  always #5 clk = ~clk;

  phy_led_mdix_bist_control #(.STRETCH_CYCLES(8)) u_phy_led_mdix_bist_control (
    .clk(clk), .reset_n(reset_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
    .strap_auto_crossover(1'b1), .strap_indicator_mode(1'b1),
    .strap_port_address(5'h15), .link_evt(link_evt),
    .local_ability(local_ability), .partner_ability(partner_ability),
    .hcd_full_duplex(hcd_full_duplex),
    .selftest_nibble_err(selftest_nibble_err),
    .link_indicator_pin(pin), .auto_crossover_enable(acen),
    .crossover_force(xf), .selftest_run(run),
    .selftest_sequence_select(seq), .selftest_error_inject(inj),
    .port_mgmt_address(paddr));

  core_model u_core_model (
    .clk(clk), .reset_n(reset_n), .err_go(err_go), .err_count(err_count),
    .selftest_run(run), .selftest_nibble_err(selftest_nibble_err));

  task test_done;
    if (fails == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  // the request stands until waitrequest is sampled low at an edge
  task bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
    address <= a;
    writedata <= {16'h0000, d};
    read <= ~wr;
    write <= wr;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask : bus

  task rchk(input logic [7:0] a, input logic [15:0] exp);
    bus(1'b0, a, 16'h0000);
    check(rd, {16'h0000, exp});
  endtask : rchk

  task errs(input logic [8:0] n);
    err_count <= n;
    err_go <= 1'b1;
    @(posedge clk);
    err_go <= 1'b0;
    idle(2 * n + 10);
  endtask : errs

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (inj === 1'b1) inj_cnt <= inj_cnt + 1;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end

  initial begin
    // {full duplex, local asm/pause, partner asm/pause, rx, tx}
    ptab = '{7'b1010111, 7'b1101101, 7'b1111010, 7'b0010100, 7'b1110000};
    idle(10);
    reset_n <= 1'b1;
    idle(10);
    // straps hold crossover on; no negotiation is modelled here
    rchk(A_CTRL, 16'h8035);
    check({27'h0, paddr}, 32'h15);
    rchk(A_LED, 16'h0000);
    bus(1'b1, A_CTRL, 16'hf7ff);
    rchk(A_CTRL, 16'hc7bf);
    check({26'h0, acen, xf, run, seq, paddr == 5'h1f, 1'b1}, 32'h3f);
    errs(9'd3);
    rchk(A_FLT, 16'h0003);
    rchk(A_CTRL, 16'hc5bf);
    rchk(A_ST, 16'h0001);
    bus(1'b1, A_CTRL, 16'hc4bf);
    rchk(A_CTRL, 16'hc4bf);
    bus(1'b1, A_CTRL, 16'hc5bf);
    rchk(A_FLT, 16'h0000);
    rchk(A_CTRL, 16'hc7bf);
    bus(1'b1, A_CTRL, 16'hcdbf);
    idle(3);
    check(inj_cnt, 32'h1);
    rchk(A_CTRL, 16'hc5bf);
    rchk(A_FLT, 16'h0000);
    bus(1'b1, A_CTRL, 16'hc4bf);
    bus(1'b1, A_CTRL, 16'hc5bf);
    errs(9'd300);
    rchk(A_FLT, 16'h00ff);
    bus(1'b1, A_CTRL, 16'h0020);
    idle(3);
    check({30'h0, acen, xf}, 32'h0);
    // sticky fail flag raises irq only while unmasked
    bus(1'b1, A_MSK, 16'h0001);
    idle(3);
    check({31'h0, irq}, 32'h1);
    bus(1'b1, A_ST, 16'h0001);
    idle(3);
    check({31'h0, irq}, 32'h0);
    rchk(A_ST, 16'h0000);
    // override wins over the link, and reads never show the pin
    link_evt.link_up <= 1'b0;
    bus(1'b1, A_LED, 16'hffff);
    idle(3);
    check({31'h0, pin}, 32'h1);
    rchk(A_LED, 16'h0012);
    // a write on the upper lane only must leave the force bits alone
    byteenable <= 4'h2;
    bus(1'b1, A_LED, 16'h0000);
    byteenable <= 4'h3;
    rchk(A_LED, 16'h0012);
    link_evt.link_up <= 1'b1;
    bus(1'b1, A_LED, 16'h0010);
    idle(3);
    check({31'h0, pin}, 32'h0);
    rchk(A_LED, 16'h0010);
    bus(1'b1, A_LED, 16'h0000);
    link_evt.activity <= 1'b1;
    idle(3);
    check({31'h0, pin}, 32'h1);
    link_evt.activity <= 1'b0;
    bus(1'b1, A_CTRL, 16'h0000);
    idle(12);
    check({31'h0, pin}, 32'h1);
    link_evt.activity <= 1'b1;
    @(posedge clk);
    link_evt.activity <= 1'b0;
    idle(3);
    check({31'h0, pin}, 32'h0);
    idle(20);
    check({31'h0, pin}, 32'h1);
    bus(1'b1, A_CTRL, 16'h0080);
    link_evt.activity <= 1'b1;
    idle(3);
    check({31'h0, pin}, 32'h0);
    link_evt.activity <= 1'b0;
    idle(3);
    check({31'h0, pin}, 32'h1);
    for (int i = 0; i < 5; i++) begin
      {hcd_full_duplex, local_ability, partner_ability} <= ptab[i][6:2];
      idle(3);
      bus(1'b0, A_CTRL, 16'h0000);
      check({30'h0, rd[13:12]}, {30'h0, ptab[i][1:0]});
    end
    rchk(A_ST, 16'h0002);
    bus(1'b1, A_MSK, 16'h0002);
    idle(3);
    check({31'h0, irq}, 32'h1);
    // unmapped index takes no write and reads zero
    bus(1'b1, 8'h00, 16'hffff);
    rchk(8'h00, 16'h0000);
    rchk(8'h7c, 16'h0000);
    test_done();
  end
endmodule : phy_led_mdix_bist_control_tb
